/* alsic_bank.sv */
// alsic_bank: application-layer state, run indicator and interface config
`timescale 1ns/10ps
`default_nettype none

module alsic_bank #(
	parameter int TICK_CYC = alsic_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// network side byte access
	input wire alsic_pkg::alsic_req_t net_req,
	output logic [7:0] net_rdata,
	output logic net_rack,
	// local host interface byte access
	input wire alsic_pkg::alsic_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_rack,
	// state control register write event
	input wire logic ctl_wr,
	input wire logic [3:0] ctl_state,
	input wire logic ctl_ack,
	// configuration loader
	input wire logic ee_load,
	input wire logic ee_ok,
	input wire logic [7:0] ee_if_sel,
	input wire logic [7:0] ee_cfg,
	// status to neighbouring logic
	output logic status_evt_clr,
	output logic run_led,
	output logic [alsic_pkg::LINK_PORTS-1:0] link_en,
	output logic emulation
);

	localparam int TW = $clog2(TICK_CYC);

	logic [3:0] st_q;
	logic err_q;
	logic [3:0] last_ctl_q;
	logic [15:0] code_q;
	logic ovr_en_q;
	logic [3:0] ovr_code_q;
	logic [7:0] if_sel_q;
	logic [7:0] cfg_q;
	logic first_done_q;
	logic [7:0] net_rdata_q;
	logic [7:0] host_rdata_q;
	logic net_rack_q;
	logic host_rack_q;
	logic evt_clr_q;
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic [3:0] led_code_q;
	logic [3:0] eff_code;
	logic restart;
	alsic_pkg::alsic_flash_t fl_st_q;
	logic [4:0] ph_q;
	logic [3:0] fl_n_q;
	logic flk_q;
	logic led_q;
	logic [alsic_pkg::LINK_PORTS-1:0] link_q;
	logic emu;
	logic host_st_wr;
	logic st_valid_chg;
	logic [3:0] state_led;

	// state code is one of the five legal values
	function automatic logic st_valid(input logic [3:0] s);
		case (s)
			alsic_pkg::ST_INIT,
			alsic_pkg::ST_PRE_OPERATIONAL_STATE,
			alsic_pkg::ST_BOOT,
			alsic_pkg::ST_SAFE_OPERATIONAL_STATE,
			alsic_pkg::ST_OP: st_valid = 1'b1;
			default: st_valid = 1'b0;
		endcase
	endfunction

	// byte read image; unmapped and reserved bytes return zero
	function automatic logic [7:0] rd_byte(input logic [11:0] a);
		case (a)
			alsic_pkg::ADDR_STATUS_LO: rd_byte = {3'b000, err_q, st_q};
			alsic_pkg::ADDR_CODE_LO: rd_byte = code_q[7:0];
			alsic_pkg::ADDR_CODE_HI: rd_byte = code_q[15:8];
			alsic_pkg::ADDR_LED_OVR: rd_byte = {3'b000, ovr_en_q, eff_code};
			alsic_pkg::ADDR_IF_SEL: rd_byte = if_sel_q;
			alsic_pkg::ADDR_CFG: rd_byte = cfg_q;
			default: rd_byte = 8'h00;
		endcase
	endfunction

	assign emu = cfg_q[alsic_pkg::CFG_EMU_BIT];
	// network writes to status and code land nowhere
	assign host_st_wr = host_req.wr && !emu &&
		(host_req.addr == alsic_pkg::ADDR_STATUS_LO);
	assign st_valid_chg = (host_st_wr && st_valid(host_req.wdata[3:0])) ||
		(emu && ctl_wr && st_valid(ctl_state));

	// indicator code the state would show without override
	always_comb begin
		case (st_q)
			alsic_pkg::ST_SAFE_OPERATIONAL_STATE: state_led = 4'h1;
			alsic_pkg::ST_PRE_OPERATIONAL_STATE: state_led = alsic_pkg::LED_BLINK;
			alsic_pkg::ST_BOOT: state_led = alsic_pkg::LED_FLICKER;
			alsic_pkg::ST_OP: state_led = alsic_pkg::LED_ON;
			default: state_led = alsic_pkg::LED_OFF;
		endcase
	end

	assign eff_code = ovr_en_q ? ovr_code_q : state_led;

	// state field and error flag
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= alsic_pkg::RST_STATUS[3:0];
			err_q <= alsic_pkg::RST_STATUS[alsic_pkg::STATUS_ERR_BIT];
			last_ctl_q <= alsic_pkg::ST_INIT;
		end else begin
			if (ctl_wr) begin
				last_ctl_q <= ctl_state;
			end
			if (emu) begin
				// mirror keeps following even without a fresh write
				st_q <= ctl_wr ? ctl_state : last_ctl_q;
			end else if (host_st_wr) begin
				st_q <= host_req.wdata[3:0];
			end
			// a host write setting the flag beats a same-cycle acknowledge
			if (host_st_wr) begin
				err_q <= host_req.wdata[alsic_pkg::STATUS_ERR_BIT];
			end else if (ctl_wr && ctl_ack) begin
				err_q <= 1'b0;
			end
		end
	end

	// status code, host side only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			code_q <= alsic_pkg::RST_CODE;
		end else if (host_req.wr) begin
			if (host_req.addr == alsic_pkg::ADDR_CODE_LO) begin
				code_q[7:0] <= host_req.wdata;
			end else if (host_req.addr == alsic_pkg::ADDR_CODE_HI) begin
				code_q[15:8] <= host_req.wdata;
			end
		end
	end

	// override register; an explicit write wins over the automatic clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_en_q <= alsic_pkg::RST_LED_OVR[alsic_pkg::OVR_EN_BIT];
			ovr_code_q <= alsic_pkg::RST_LED_OVR[3:0];
		end else if (net_req.wr && net_req.addr == alsic_pkg::ADDR_LED_OVR) begin
			ovr_en_q <= net_req.wdata[alsic_pkg::OVR_EN_BIT];
			ovr_code_q <= net_req.wdata[3:0];
		end else if (host_req.wr &&
			host_req.addr == alsic_pkg::ADDR_LED_OVR) begin
			ovr_en_q <= host_req.wdata[alsic_pkg::OVR_EN_BIT];
			ovr_code_q <= host_req.wdata[3:0];
		end else if (st_valid_chg) begin
			ovr_en_q <= 1'b0;
		end
	end

	// select and configuration from the loader
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			if_sel_q <= alsic_pkg::RST_IF_SEL;
			cfg_q <= alsic_pkg::RST_CFG;
			first_done_q <= 1'b0;
		end else if (ee_load) begin
			first_done_q <= 1'b1;
			if (ee_ok) begin
				if_sel_q <= ee_if_sel;
			end
			// a failed first load still uses up the one chance
			if (ee_ok && !first_done_q) begin
				cfg_q <= (ee_cfg & (alsic_pkg::CFG_FIRST_MASK |
					alsic_pkg::CFG_RELOAD_MASK));
			end else if (ee_ok) begin
				cfg_q <= (cfg_q & ~alsic_pkg::CFG_RELOAD_MASK) |
					(ee_cfg & alsic_pkg::CFG_RELOAD_MASK);
			end
		end
	end

	// enhanced link enables per port
	genvar gi;
	generate
		for (gi = 0; gi < alsic_pkg::LINK_PORTS; gi++) begin : g_link
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					link_q[gi] <= 1'b0;
				end else begin
					link_q[gi] <= cfg_q[alsic_pkg::CFG_LINK_P0_BIT + gi] |
						cfg_q[alsic_pkg::CFG_ALL_LINK_BIT];
				end
			end
		end
	endgenerate

	// read answers and the status event clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			net_rdata_q <= 8'h00;
			host_rdata_q <= 8'h00;
			net_rack_q <= 1'b0;
			host_rack_q <= 1'b0;
			evt_clr_q <= 1'b0;
		end else begin
			net_rack_q <= net_req.rd;
			host_rack_q <= host_req.rd;
			if (net_req.rd) begin
				net_rdata_q <= rd_byte(net_req.addr);
			end
			if (host_req.rd) begin
				host_rdata_q <= rd_byte(host_req.addr);
			end
			// either byte of the status register counts as a read
			evt_clr_q <= net_req.rd &&
				(net_req.addr == alsic_pkg::ADDR_STATUS_LO ||
				net_req.addr == alsic_pkg::ADDR_STATUS_HI);
		end
	end

	// time base for indicator patterns
	assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
		end
	end

	assign restart = (eff_code != led_code_q);

	// flash, blink and flicker sequencer; a new code restarts the pattern
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			led_code_q <= alsic_pkg::LED_OFF;
			fl_st_q <= alsic_pkg::FL_ON;
			ph_q <= 5'h0;
			fl_n_q <= 4'h0;
			flk_q <= 1'b1;
		end else begin
			led_code_q <= eff_code;
			if (restart) begin
				fl_st_q <= alsic_pkg::FL_ON;
				ph_q <= 5'h0;
				fl_n_q <= 4'h0;
				flk_q <= 1'b1;
			end else if (tick) begin
				flk_q <= !flk_q;
				case (fl_st_q)
					alsic_pkg::FL_ON: begin
						if (ph_q == 5'(alsic_pkg::FLASH_ON_TICKS - 1)) begin
							ph_q <= 5'h0;
							fl_n_q <= fl_n_q + 4'h1;
							if (led_code_q <= alsic_pkg::LED_FLASH_MAX &&
								fl_n_q + 4'h1 == led_code_q) begin
								fl_st_q <= alsic_pkg::FL_PAUSE;
							end else begin
								fl_st_q <= alsic_pkg::FL_GAP;
							end
						end else begin
							ph_q <= ph_q + 5'h1;
						end
					end
					alsic_pkg::FL_GAP: begin
						if (ph_q == 5'(alsic_pkg::FLASH_GAP_TICKS - 1)) begin
							ph_q <= 5'h0;
							fl_st_q <= alsic_pkg::FL_ON;
						end else begin
							ph_q <= ph_q + 5'h1;
						end
					end
					alsic_pkg::FL_PAUSE: begin
						if (ph_q == 5'(alsic_pkg::FLASH_PAUSE_TICKS - 1)) begin
							ph_q <= 5'h0;
							fl_n_q <= 4'h0;
							fl_st_q <= alsic_pkg::FL_ON;
						end else begin
							ph_q <= ph_q + 5'h1;
						end
					end
					default: begin
						fl_st_q <= alsic_pkg::FL_ON;
						ph_q <= 5'h0;
					end
				endcase
			end
		end
	end

	// indicator level from the active code
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			led_q <= 1'b0;
		end else begin
			case (led_code_q)
				alsic_pkg::LED_OFF: led_q <= 1'b0;
				alsic_pkg::LED_ON: led_q <= 1'b1;
				alsic_pkg::LED_FLICKER: led_q <= flk_q;
				default: led_q <= (fl_st_q == alsic_pkg::FL_ON) && !restart;
			endcase
		end
	end

	assign net_rdata = net_rdata_q;
	assign host_rdata = host_rdata_q;
	assign net_rack = net_rack_q;
	assign host_rack = host_rack_q;
	assign status_evt_clr = evt_clr_q;
	assign run_led = led_q;
	assign link_en = link_q;
	assign emulation = cfg_q[alsic_pkg::CFG_EMU_BIT];

endmodule

`default_nettype wire

/* alsic_pkg.sv */
// alsic_pkg: constants, types and register map of the state and config bank
`default_nettype none

package alsic_pkg;

	// register byte addresses, lowest byte holds the least significant byte
	localparam logic [11:0] ADDR_STATUS_LO = 12'h0130;
	localparam logic [11:0] ADDR_STATUS_HI = 12'h0131;
	localparam logic [11:0] ADDR_CODE_LO = 12'h0134;
	localparam logic [11:0] ADDR_CODE_HI = 12'h0135;
	localparam logic [11:0] ADDR_LED_OVR = 12'h0138;
	localparam logic [11:0] ADDR_IF_SEL = 12'h0140;
	localparam logic [11:0] ADDR_CFG = 12'h0141;

	// state codes shared by status and control fields
	localparam logic [3:0] ST_INIT = 4'h1;
	localparam logic [3:0] ST_PRE_OPERATIONAL_STATE = 4'h2;
	localparam logic [3:0] ST_BOOT = 4'h3;
	localparam logic [3:0] ST_SAFE_OPERATIONAL_STATE = 4'h4;
	localparam logic [3:0] ST_OP = 4'h8;

	// field positions
	localparam int STATUS_ERR_BIT = 4;
	localparam int OVR_EN_BIT = 4;
	localparam int CFG_EMU_BIT = 0;
	localparam int CFG_ALL_LINK_BIT = 1;
	localparam int CFG_LINK_P0_BIT = 4;
	localparam int LINK_PORTS = 3;

	// config bits taken on first load only, and on every good load
	localparam logic [7:0] CFG_FIRST_MASK = 8'h72;
	localparam logic [7:0] CFG_RELOAD_MASK = 8'h0D;

	// reset values
	localparam logic [15:0] RST_STATUS = 16'h0001;
	localparam logic [15:0] RST_CODE = 16'h0000;
	localparam logic [7:0] RST_LED_OVR = 8'h00;
	localparam logic [7:0] RST_IF_SEL = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;

	// interface select codes
	localparam logic [7:0] IF_DIGITAL_IO = 8'h04;
	localparam logic [7:0] IF_SERIAL = 8'h80;
	localparam logic [7:0] IF_PHB_MUX1_8 = 8'h88;
	localparam logic [7:0] IF_PHB_MUX1_16 = 8'h89;
	localparam logic [7:0] IF_PHB_MUX2_8 = 8'h8A;
	localparam logic [7:0] IF_PHB_MUX2_16 = 8'h8B;
	localparam logic [7:0] IF_PHB_IDX_8 = 8'h8C;
	localparam logic [7:0] IF_PHB_IDX_16 = 8'h8D;

	// run indicator codes
	localparam logic [3:0] LED_OFF = 4'h0;
	localparam logic [3:0] LED_FLASH_MAX = 4'hC;
	localparam logic [3:0] LED_BLINK = 4'hD;
	localparam logic [3:0] LED_FLICKER = 4'hE;
	localparam logic [3:0] LED_ON = 4'hF;

	// indicator timing, times in ms and derived counts
	localparam int CLK_KHZ = 25000;
	localparam int TICK_MS = 50;
	localparam int TICK_CYC = TICK_MS * CLK_KHZ;
	localparam int FLASH_ON_MS = 200;
	localparam int FLASH_GAP_MS = 200;
	localparam int FLASH_PAUSE_MS = 1000;
	localparam int FLASH_ON_TICKS = FLASH_ON_MS / TICK_MS;
	localparam int FLASH_GAP_TICKS = FLASH_GAP_MS / TICK_MS;
	localparam int FLASH_PAUSE_TICKS = FLASH_PAUSE_MS / TICK_MS;

	// one byte access from either party
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} alsic_req_t;

	// indicator pattern phases
	typedef enum logic [2:0] {
		FL_ON = 3'b001,
		FL_GAP = 3'b010,
		FL_PAUSE = 3'b100
	} alsic_flash_t;

endpackage

`default_nettype wire

/* alsic_checker.sv */
// alsic_checker: port assertions for the state and config bank
`timescale 1ns/10ps
`default_nettype none

module alsic_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// bus sides
	input wire alsic_pkg::alsic_req_t net_req,
	input wire logic [7:0] net_rdata,
	input wire logic net_rack,
	input wire alsic_pkg::alsic_req_t host_req,
	input wire logic host_rack,
	// control and status
	input wire logic ctl_wr,
	input wire logic [3:0] ctl_state,
	input wire logic status_evt_clr,
	input wire logic [alsic_pkg::LINK_PORTS-1:0] link_en,
	input wire logic emulation
);
	logic st_rd;
	logic lo_rd;
	logic hi_rd;
	logic cfg_rd;
	logic ovr_rd;
	assign lo_rd = net_req.rd &&
		net_req.addr == alsic_pkg::ADDR_STATUS_LO;
	assign hi_rd = net_req.rd &&
		net_req.addr == alsic_pkg::ADDR_STATUS_HI;
	assign st_rd = lo_rd || hi_rd;
	assign cfg_rd = net_req.rd && net_req.addr == alsic_pkg::ADDR_CFG;
	assign ovr_rd = net_req.rd &&
		net_req.addr == alsic_pkg::ADDR_LED_OVR;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_net_rack: assert property (net_rack == $past(net_req.rd))
		else $error("network read ack off");
	a_host_rack: assert property (host_req.rd |=> host_rack)
		else $error("host read ack missing");
	a_evt_clr: assert property (st_rd |=> status_evt_clr)
		else $error("status event not cleared");
	a_evt_cause: assert property (status_evt_clr |-> $past(st_rd))
		else $error("status event cleared without read");
	a_emul_bit: assert property (cfg_rd |=> net_rdata[0] == emulation)
		else $error("emulation differs from config bit");
	a_link_or: assert property (cfg_rd |=> ##1 link_en ==
		({3{$past(net_rdata[1])}} | $past(net_rdata[6:4])))
		else $error("link enable mismatch");
	a_hi_zero: assert property (hi_rd |=> net_rdata == 8'h00)
		else $error("status high byte not zero");
	a_ovr_rsvd: assert property (ovr_rd |=> net_rdata[7:5] == 3'b000)
		else $error("override reserved bits set");
	a_state_mirror: assert property (ctl_wr && emulation ##2 lo_rd
		|=> net_rdata[3:0] == $past(ctl_state, 3))
		else $error("status does not mirror control");
endmodule

bind alsic_bank alsic_checker chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.net_req(net_req), .net_rdata(net_rdata), .net_rack(net_rack),
	.host_req(host_req), .host_rack(host_rack), .ctl_wr(ctl_wr),
	.ctl_state(ctl_state), .status_evt_clr(status_evt_clr),
	.link_en(link_en), .emulation(emulation));

`default_nettype wire

/* alsic_loader_model.sv */
// alsic_loader_model: configuration image loader feeding the bank
`timescale 1ns/10ps
`default_nettype none

module alsic_loader_model #(
	parameter int LOAD_CYC = 6
) (
	// clock
	input wire logic ref_clk,
	// load request and image contents
	input wire logic go,
	input wire logic img_good,
	input wire logic [7:0] img_if,
	input wire logic [7:0] img_cfg,
	// towards the bank
	output logic ee_load,
	output logic ee_ok,
	output logic [7:0] ee_if_sel,
	output logic [7:0] ee_cfg
);
	int cnt = 0;
	initial begin
		ee_load = 1'b0;
		ee_ok = 1'b0;
		ee_if_sel = 8'h00;
		ee_cfg = 8'h00;
	end
	always @(posedge ref_clk) begin
		ee_load <= 1'b0;
		// bytes only count with the strobe, so keep them moving otherwise
		ee_ok <= ~ee_ok;
		ee_if_sel <= ~ee_if_sel;
		ee_cfg <= ~ee_cfg;
		if (go) begin
			cnt <= LOAD_CYC;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			ee_load <= 1'b1;
			ee_ok <= img_good;
			ee_if_sel <= img_if;
			ee_cfg <= img_cfg;
		end
	end
endmodule

`default_nettype wire

/* testbench.sv */
// testbench: directed scenarios for the state and config bank
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic ref_clk = 0;
	logic rst_b = 0;
	alsic_pkg::alsic_req_t net_req = '0;
	alsic_pkg::alsic_req_t host_req = '0;
	logic [7:0] net_rdata, host_rdata, rd_byte;
	logic net_rack, host_rack, status_evt_clr, run_led, emulation;
	logic [2:0] link_en;
	logic ctl_wr = 0, ctl_ack = 0, go = 0, img_good = 0;
	logic [3:0] ctl_state = 4'h0;
	logic ee_load, ee_ok;
	logic [7:0] ee_if_sel, ee_cfg, img_if = 8'h00, img_cfg = 8'h00;
	int err_count = 0, compares = 0;
	// short indicator tick so patterns fit in a few hundred cycles
	localparam int TICK = 4;

	always #20 ref_clk = ~ref_clk;

	alsic_bank #(.TICK_CYC(TICK)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.net_req(net_req), .net_rdata(net_rdata), .net_rack(net_rack),
		.host_req(host_req), .host_rdata(host_rdata),
		.host_rack(host_rack), .ctl_wr(ctl_wr), .ctl_state(ctl_state),
		.ctl_ack(ctl_ack), .ee_load(ee_load), .ee_ok(ee_ok),
		.ee_if_sel(ee_if_sel), .ee_cfg(ee_cfg),
		.status_evt_clr(status_evt_clr), .run_led(run_led),
		.link_en(link_en), .emulation(emulation));

	alsic_loader_model loader (.ref_clk(ref_clk), .go(go),
		.img_good(img_good), .img_if(img_if), .img_cfg(img_cfg),
		.ee_load(ee_load), .ee_ok(ee_ok), .ee_if_sel(ee_if_sel),
		.ee_cfg(ee_cfg));

	task automatic close_out;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic acc(input bit h, input bit w, input logic [11:0] a,
		input logic [7:0] d);
		alsic_pkg::alsic_req_t r;
		r = '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge ref_clk);
		if (h) host_req <= r;
		else net_req <= r;
		@(posedge ref_clk);
		host_req <= '0;
		net_req <= '0;
		#1;
		rd_byte = h ? host_rdata : net_rdata;
	endtask

	task automatic rd_chk(input bit h, input logic [11:0] a,
		input logic [7:0] e);
		acc(h, 0, a, 8'h00);
		check(rd_byte, e);
	endtask

	task automatic ctl(input logic [3:0] s, input logic k);
		@(posedge ref_clk);
		ctl_wr <= 1;
		ctl_state <= s;
		ctl_ack <= k;
		@(posedge ref_clk);
		ctl_wr <= 0;
		ctl_ack <= 0;
	endtask

	task automatic load(input logic g, input logic [7:0] i, input logic [7:0] c);
		int n;
		@(posedge ref_clk);
		go <= 1;
		img_good <= g;
		img_if <= i;
		img_cfg <= c;
		@(posedge ref_clk);
		go <= 0;
		for (n = 0; n < 20 && ee_load !== 1'b1; n++) @(posedge ref_clk) #1;
		// link enables settle one cycle after the registers
		repeat (2) @(posedge ref_clk);
	endtask

	// counts high cycles over one whole period of an n-flash pattern
	task automatic led_flash(input int n);
		int per;
		int hi;
		per = (n * alsic_pkg::FLASH_ON_TICKS + (n - 1) *
			alsic_pkg::FLASH_GAP_TICKS + alsic_pkg::FLASH_PAUSE_TICKS) * TICK;
		hi = 0;
		repeat (per) @(posedge ref_clk);
		repeat (per) begin
			@(posedge ref_clk);
			#1;
			hi += int'(run_led);
		end
		check(8'(hi), 8'(n * alsic_pkg::FLASH_ON_TICKS * TICK));
	endtask

	task automatic do_reset;
		@(posedge ref_clk);
		rst_b <= 0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1;
	endtask

	task automatic t_reset;
		logic [11:0] ra [8] = '{12'h130, 12'h131, 12'h134, 12'h135,
			12'h138, 12'h140, 12'h141, 12'h200};
		for (int h = 0; h < 2; h++)
			for (int i = 0; i < 8; i++)
				rd_chk(h[0], ra[i], i == 0 ? 8'h01 : 8'h00);
	endtask

	task automatic t_state;
		logic [7:0] st [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
		logic [7:0] ld [5] = '{8'h00, 8'h0D, 8'h0E, 8'h01, 8'h0F};
		for (int i = 0; i < 5; i++) begin
			acc(1, 1, 12'h130, st[i]);
			rd_chk(0, 12'h130, st[i]);
			rd_chk(1, 12'h138, ld[i]);
		end
		acc(1, 1, 12'h130, 8'h12);
		rd_chk(0, 12'h130, 8'h12);
		ctl(4'h8, 1);
		rd_chk(0, 12'h130, 8'h02);
		acc(0, 1, 12'h130, 8'h04);
		rd_chk(1, 12'h130, 8'h02);
		acc(0, 1, 12'h138, 8'h1D);
		rd_chk(1, 12'h138, 8'h1D);
		acc(1, 1, 12'h138, 8'h1F);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, run_led}, 8'h01);
		acc(0, 1, 12'h138, 8'h12);
		led_flash(2);
		acc(0, 1, 12'h138, 8'h10);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, run_led}, 8'h00);
		acc(1, 1, 12'h130, 8'h08);
		rd_chk(0, 12'h138, 8'h0F);
		acc(1, 1, 12'h130, 8'h04);
		led_flash(1);
	endtask

	task automatic t_code;
		acc(1, 1, 12'h134, 8'hEF);
		acc(1, 1, 12'h135, 8'hBE);
		acc(0, 1, 12'h134, 8'h00);
		acc(1, 1, 12'h140, 8'h55);
		rd_chk(0, 12'h134, 8'hEF);
		rd_chk(0, 12'h135, 8'hBE);
		rd_chk(0, 12'h140, 8'h00);
	endtask

	task automatic t_load;
		load(1, 8'h89, 8'h12);
		rd_chk(0, 12'h141, 8'h12);
		check({5'h00, link_en}, 8'h07);
		// each host bus select code reads back from the host side as loaded
		for (int c = 8'h88; c <= 8'h8D; c++) begin
			load(1, c[7:0], 8'h12);
			rd_chk(1, 12'h140, c[7:0]);
		end
		load(1, 8'h04, 8'h61);
		rd_chk(1, 12'h141, 8'h13);
		rd_chk(1, 12'h140, 8'h04);
		check({7'h00, emulation}, 8'h01);
		ctl(4'h4, 1);
		rd_chk(0, 12'h130, 8'h04);
		acc(1, 1, 12'h130, 8'h08);
		rd_chk(0, 12'h130, 8'h04);
	endtask

	task automatic t_fail;
		do_reset();
		load(0, 8'h80, 8'h7F);
		rd_chk(0, 12'h141, 8'h00);
		load(1, 8'h80, 8'h7E);
		rd_chk(0, 12'h141, 8'h0C);
		check({5'h00, link_en}, 8'h00);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		close_out();
	end

	initial begin
		do_reset();
		t_reset();
		t_state();
		t_code();
		t_load();
		t_fail();
		close_out();
	end
endmodule

`default_nettype wire
